//--- design/dcp_top.sv
// Drive command parser: APB command port, settings, analog deadband
module dcp_top
  import dcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic buf_hold,
  input wire logic signed [15:0] ana_sample,
  input wire logic ana_valid,
  input wire logic [1:0] ana_chan,
  output logic signed [16:0] analog_cmd,
  output logic [15:0] ramp_up_rate,
  output logic [31:0] move_length,
  output logic [7:0] control_mode_select,
  output logic nv_save
);
  //------------------------------------------------------------
  // Storage
  //------------------------------------------------------------
  logic [19:0] cmd_q;
  logic [31:0] param_q;
  logic [19:0] pend_cmd_q;
  logic [31:0] pend_param_q;
  logic pend_q;
  logic [15:0] x_code;
  logic x_has;
  logic x_has_chan;
  logic [1:0] x_chan;
  logic [31:0] x_param;
  logic go_q;
  dcp_state_t st_q;
  logic [15:0] ramp_q;
  logic [31:0] move_q;
  logic [7:0] mode_q;
  logic [7:0] db_q [DB_CHANNELS];
  logic [15:0] nv_ramp_q;
  logic [31:0] nv_move_q;
  logic [7:0] nv_mode_q;
  logic [7:0] nv_db_q [DB_CHANNELS];
  logic [15:0] zero_q;
  logic signed [16:0] ana_q;
  logic [15:0] rep_code_q;
  logic [31:0] rep_val_q;
  logic rep_valid_q;
  logic err_q;
  logic [31:0] prdata_q;
  logic nv_save_q;

  //------------------------------------------------------------
  // APB slave
  //------------------------------------------------------------
  logic busy, cmd_imm, go_blk, acc, wr, rd, go_acc, rel, mapped;

  assign busy = go_q || st_q != DCP_ST_IDLE;
  assign cmd_imm = dcp_is_immediate(cmd_q[15:0]); // [R02]
  // Stall rather than drop: a buffered command waits behind the pending one
  assign go_blk = busy || (!cmd_imm && pend_q);
  // A frozen clock enable holds the access phase so no transfer is lost
  assign pready = ce && !(psel && pwrite && paddr == OFS_GO && go_blk);
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign go_acc = wr && paddr == OFS_GO;
  assign rel = pend_q && !buf_hold && !busy && !go_acc; // [R02]
  assign mapped = paddr[1:0] == 2'b00 && paddr <= OFS_NV;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_q;

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (ce && psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CMD: prdata_q <= {12'h000, cmd_q};
        OFS_PARAM: prdata_q <= param_q;
        OFS_STAT: prdata_q <= {28'h0000000, busy, pend_q, err_q, rep_valid_q};
        OFS_RCODE: prdata_q <= {16'h0000, rep_code_q};
        OFS_RVAL: prdata_q <= rep_val_q;
        OFS_ANA: prdata_q <= {{15{ana_q[16]}}, ana_q};
        OFS_ZERO: prdata_q <= {16'h0000, zero_q};
        OFS_NV: prdata_q <= {nv_mode_q, 8'h00, nv_ramp_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
      param_q <= '0;
      zero_q <= '0;
    end else if (ce && wr) begin
      if (paddr == OFS_CMD) cmd_q <= pwdata[19:0]; // [R01]
      if (paddr == OFS_PARAM) param_q <= pwdata;
      if (paddr == OFS_ZERO) zero_q <= pwdata[15:0];
    end
  end

  //------------------------------------------------------------
  // Dispatch: immediate at once, buffered in order
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pend_cmd_q <= '0;
      pend_param_q <= '0;
      go_q <= 1'b0;
      x_code <= '0;
      x_has <= 1'b0;
      x_has_chan <= 1'b0;
      x_chan <= '0;
      x_param <= '0;
    end else if (ce) begin
      go_q <= 1'b0;
      if (go_acc && !cmd_imm && buf_hold) begin
        pend_q <= 1'b1; // [R02]
        pend_cmd_q <= cmd_q;
        pend_param_q <= param_q;
      end else if (go_acc) begin
        go_q <= 1'b1; // [R02]
        {x_chan, x_has_chan, x_has, x_code} <= cmd_q; // [R01]
        x_param <= param_q;
      end else if (rel) begin
        pend_q <= 1'b0;
        go_q <= 1'b1;
        {x_chan, x_has_chan, x_has, x_code} <= pend_cmd_q;
        x_param <= pend_param_q;
      end
    end
  end

  //------------------------------------------------------------
  // Command decode
  //------------------------------------------------------------
  logic ch_ok, rep_set, err_set, div_go, save_go, wr_db, wr_move, wr_mode;
  logic [1:0] ch_idx;
  logic [31:0] rep_val_d;

  assign ch_ok = !x_has_chan || x_chan != 2'b00; // [R14]
  assign ch_idx = x_has_chan ? x_chan - 2'b01 : 2'b00;

  always_comb begin
    rep_set = 1'b0;
    err_set = 1'b0;
    div_go = 1'b0;
    save_go = 1'b0;
    wr_db = 1'b0;
    wr_move = 1'b0;
    wr_mode = 1'b0;
    rep_val_d = '0;
    if (go_q) begin
      case (x_code)
        CODE_RAMP_UP_RATE: begin
          if (!x_has) begin
            rep_set = 1'b1; // [R03]
            rep_val_d = 32'(32'(ramp_q) * RAMP_STEP);
          end else if (x_param >= RAMP_MIN && x_param <= RAMP_MAX) begin
            div_go = 1'b1; // [R07]
          end else begin
            err_set = 1'b1; // [R15]
          end
        end
        CODE_DEADBAND: begin
          if (!ch_ok || (x_has && x_param > DB_MAX)) begin
            err_set = 1'b1; // [R15]
          end else if (x_has) begin
            wr_db = 1'b1; // [R09] [R14]
          end else begin
            rep_set = 1'b1; // [R09]
            rep_val_d = 32'(db_q[ch_idx]);
          end
        end
        CODE_MOVE_LENGTH: begin
          if (!x_has) begin
            rep_set = 1'b1;
            rep_val_d = move_q;
          end else if (x_param == MOVE_ILLEGAL) begin
            err_set = 1'b1; // [R06]
          end else begin
            wr_move = 1'b1;
          end
        end
        CODE_CONTROL_MODE_SELECT: begin
          if (!x_has) begin
            rep_set = 1'b1;
            rep_val_d = 32'(mode_q);
          end else if (x_param > MODE_MAX) begin
            err_set = 1'b1;
          end else begin
            wr_mode = 1'b1;
          end
        end
        CODE_STORE_SETTINGS: save_go = 1'b1; // [R04]
        CODE_REGISTER_QUERY: begin
          rep_set = x_has;
          err_set = !x_has;
          case (x_param)
            DREG_RAMP: rep_val_d = 32'(ramp_q); // [R08]
            DREG_MOVE: rep_val_d = move_q; // [R05]
            DREG_ANA: rep_val_d = 32'(unsigned'(ana_q)); // [R13]
            default: begin
              rep_set = 1'b0;
              err_set = 1'b1;
            end
          endcase
        end
        default: err_set = 1'b1;
      endcase
    end
  end

  //------------------------------------------------------------
  // Ramp rate quantisation
  //------------------------------------------------------------
  logic div_done;
  logic [31:0] div_quo;

  dcp_div #(.W(32)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(div_go),
    .dividend(32'(x_param + RAMP_ROUND)),
    .divisor(RAMP_STEP),
    .busy(),
    .done(div_done),
    .quotient(div_quo)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= DCP_ST_IDLE;
    end else if (ce) begin
      case (st_q)
        DCP_ST_IDLE: if (div_go) st_q <= DCP_ST_DIV;
        DCP_ST_DIV: if (div_done) st_q <= DCP_ST_FIN;
        DCP_ST_FIN: st_q <= DCP_ST_IDLE;
        default: st_q <= DCP_ST_IDLE;
      endcase
    end
  end

  //------------------------------------------------------------
  // Working and persistent settings
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_q <= '0;
      move_q <= '0;
      mode_q <= '0;
      for (int i = 0; i < DB_CHANNELS; i++) db_q[i] <= '0;
    end else if (ce) begin
      // Register 017 keeps steps; bare-code replies give thousandths of rps/s
      if (st_q == DCP_ST_FIN) ramp_q <= div_quo[15:0]; // [R07] [R08]
      if (wr_move) move_q <= x_param; // [R06] [R03]
      if (wr_mode) mode_q <= x_param[7:0];
      if (wr_db) db_q[ch_idx] <= x_param[7:0]; // [R14]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_ramp_q <= '0;
      nv_move_q <= '0;
      nv_mode_q <= '0;
      nv_save_q <= 1'b0;
      for (int i = 0; i < DB_CHANNELS; i++) nv_db_q[i] <= '0;
    end else if (ce) begin
      nv_save_q <= save_go;
      if (save_go) begin
        nv_ramp_q <= ramp_q; // [R04]
        nv_move_q <= move_q;
        nv_mode_q <= mode_q;
        for (int i = 0; i < DB_CHANNELS; i++) nv_db_q[i] <= db_q[i];
      end
    end
  end

  //------------------------------------------------------------
  // Reply and error flags
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_code_q <= '0;
      rep_val_q <= '0;
      rep_valid_q <= 1'b0;
      err_q <= 1'b0;
    end else if (ce) begin
      // A new event wins over a clear in the same cycle
      if (rep_set) begin
        rep_valid_q <= 1'b1; // [R03]
        rep_code_q <= x_code;
        rep_val_q <= rep_val_d;
      end else if (rd && paddr == OFS_RCODE) begin
        rep_valid_q <= 1'b0;
      end
      if (err_set) err_q <= 1'b1; // [R15]
      else if (wr && paddr == OFS_STAT && pwdata[STAT_ERR]) err_q <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Analog deadband and hysteresis
  //------------------------------------------------------------
  logic signed [16:0] ana_d;
  logic signed [17:0] ana_step;
  logic [16:0] ana_mag;
  logic [17:0] step_mag;
  logic [7:0] db_sel;
  logic pos_mode;


  assign ana_d = 17'(ana_sample) - 17'($signed(zero_q));
  assign ana_step = 18'(ana_d) - 18'(ana_q);
  assign ana_mag = ana_d[16] ? 17'(-ana_d) : 17'(ana_d);
  assign step_mag = ana_step[17] ? 18'(-ana_step) : 18'(ana_step);
  assign db_sel = ana_chan == 2'b11 ? 8'h00 : db_q[ana_chan];
  assign pos_mode = mode_q == MODE_ANALOG_POSITION;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_q <= '0;
    end else if (ce && ana_valid) begin
      if (pos_mode) begin
        if (step_mag > 18'(db_sel)) ana_q <= ana_d; // [R12]
      end else begin
        ana_q <= ana_mag <= 17'(db_sel) ? 17'sd0 : ana_d; // [R10] [R11] [R13]
      end
    end
  end

  assign analog_cmd = ana_q;
  assign ramp_up_rate = ramp_q;
  assign move_length = move_q;
  assign control_mode_select = mode_q;
  assign nv_save = nv_save_q;

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_ramp_set;
    ce && go_q && x_code == CODE_RAMP_UP_RATE && x_has && div_go;
  endsequence

  chk_set_silent: assert property (ce && go_q && x_has && x_code != CODE_REGISTER_QUERY // [R03]
      |=> !($rose(rep_valid_q))) else $error("set command produced a reply");
  chk_query_reply: assert property (ce && go_q && !x_has && x_code == CODE_RAMP_UP_RATE // [R03]
      |=> rep_valid_q && rep_code_q == CODE_RAMP_UP_RATE) else $error("bare code gave no reply");
  chk_reject_keep: assert property (ce && go_q && x_code == CODE_DEADBAND && x_param > DB_MAX // [R15]
      && x_has |=> err_q && $stable(db_q[0])) else $error("bad deadband accepted");
  chk_save_copy: assert property (ce && save_go // [R04]
      |=> nv_save && nv_ramp_q == $past(ramp_q)) else $error("save did not copy settings");
  chk_nv_hold: assert property (!save_go |=> $stable(nv_ramp_q) && $stable(nv_move_q)) // [R04]
      else $error("persistent copy changed without save");
  chk_ramp_quant: assert property (seq_ramp_set |-> ##[30:40] st_q == DCP_ST_FIN ##1 // [R07]
      (32'(ramp_q) * RAMP_STEP + RAMP_ROUND >= x_param
       && 32'(ramp_q) * RAMP_STEP <= x_param + RAMP_ROUND)) else $error("ramp rate misquantised");
  chk_move_store: assert property (ce && wr_move |=> move_q == $past(x_param)) // [R06]
      else $error("move length not stored");
  chk_dead_zero: assert property (ce && ana_valid && !pos_mode && ana_mag <= 17'(db_sel) // [R10]
      |=> ana_q == 17'sd0) else $error("reading in deadband not zero");
  chk_hyst_hold: assert property (ce && ana_valid && pos_mode && step_mag <= 18'(db_sel) // [R12]
      |=> $stable(ana_q)) else $error("hysteresis did not hold output");
endmodule // dcp_top

//--- design/dcp_pkg.sv
// Constants, types and register map of the drive command parser
//------------------------------------------------------------
// Behaviour
// R01: Two-letter code, then optional or required parameters
// R02: Each command is buffered or immediate
// R03: Parameter stores silently; bare code replies value
// R04: Persistent copy changes only on save command
// R05: Command writes keep readable data registers current
// R06: Move length signed, magnitude up to 2147483647
// R07: Ramp rate 0.167..5461.167, steps of 0.167
// R08: Ramp rate also updates register 017, converted
// R09: Deadband 0..255 mV, returned on bare code
// R10: Readings within deadband of zero become zero
// R11: Deadband zero is velocity or position zero
// R12: Position mode uses deadband as hysteresis
// R13: Deadband change alters reported analog command
// R14: Channel 1..3 selects input, deadband 0..255
// R15: Out-of-range parameter rejected, setting kept
//------------------------------------------------------------
package dcp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_PARAM = 8'h04;
  localparam logic [7:0] OFS_GO = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_RCODE = 8'h10;
  localparam logic [7:0] OFS_RVAL = 8'h14;
  localparam logic [7:0] OFS_ANA = 8'h18;
  localparam logic [7:0] OFS_ZERO = 8'h1c;
  localparam logic [7:0] OFS_NV = 8'h20;
  // Command register fields
  localparam int CMD_HAS_PARAM = 16;
  localparam int CMD_HAS_CHAN = 17;
  localparam int CMD_CHAN_LSB = 18;
  // Status register bits
  localparam int STAT_REPLY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_PEND = 2;
  localparam int STAT_BUSY = 3;
  // Two-letter ASCII command codes
  localparam logic [15:0] CODE_RAMP_UP_RATE = 16'h4143;
  localparam logic [15:0] CODE_DEADBAND = 16'h4144;
  localparam logic [15:0] CODE_MOVE_LENGTH = 16'h4449;
  localparam logic [15:0] CODE_STORE_SETTINGS = 16'h5341;
  localparam logic [15:0] CODE_REGISTER_QUERY = 16'h524c;
  localparam logic [15:0] CODE_CONTROL_MODE_SELECT = 16'h434d;
  // Ramp rate in thousandths of rps/s, quantised to 167 per step
  localparam logic [31:0] RAMP_MIN = 32'h0000_00a7;
  localparam logic [31:0] RAMP_MAX = 32'h0053_54af;
  localparam logic [31:0] RAMP_STEP = 32'h0000_00a7;
  localparam logic [31:0] RAMP_ROUND = 32'h0000_0053;
  localparam logic [31:0] DB_MAX = 32'h0000_00ff;
  localparam logic [31:0] MODE_MAX = 32'h0000_00ff;
  localparam logic [31:0] MOVE_ILLEGAL = 32'h8000_0000;
  localparam logic [7:0] MODE_ANALOG_POSITION = 8'h16;
  // Data register numbers reachable by register_query
  localparam logic [31:0] DREG_RAMP = 32'h0000_0011;
  localparam logic [31:0] DREG_MOVE = 32'h0000_0014;
  localparam logic [31:0] DREG_ANA = 32'h0000_000a;
  localparam int DB_CHANNELS = 3;

  typedef enum logic [1:0] {
    DCP_ST_IDLE = 2'b00,
    DCP_ST_DIV = 2'b01,
    DCP_ST_FIN = 2'b11
  } dcp_state_t;

  function automatic logic dcp_is_immediate(input logic [15:0] code);
    return code == CODE_REGISTER_QUERY;
  endfunction
endpackage

//--- design/dcp_div.sv
// Sequential unsigned divider used for ramp rate quantisation
module dcp_div #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic [W-1:0] dividend,
  input wire logic [W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [W-1:0] quotient
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0] rem_q;
  logic [W-1:0] quo_q;
  logic [W-1:0] div_q;
  logic [CW-1:0] cnt_q;
  logic [W:0] rem_sh;

  // One quotient bit per cycle: small area, W cycles of latency
  assign rem_sh = {rem_q, quo_q[W-1]};
  assign busy = cnt_q != '0;
  assign quotient = quo_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= '0;
      quo_q <= '0;
      div_q <= '0;
      cnt_q <= '0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_q <= '0;
        quo_q <= dividend;
        div_q <= divisor;
        cnt_q <= CW'(W);
      end else if (busy) begin
        if (rem_sh >= {1'b0, div_q}) begin
          rem_q <= W'(rem_sh - {1'b0, div_q});
          quo_q <= {quo_q[W-2:0], 1'b1};
        end else begin
          rem_q <= rem_sh[W-1:0];
          quo_q <= {quo_q[W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        done <= cnt_q == CW'(1);
      end
    end
  end
endmodule // dcp_div

//--- sim/dcp_host_model.sv
// Host controller model: APB master that issues two-letter command words
module dcp_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcp_pkg::*;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  //------------------------------------------------------------
  // Bus cycle: request held until pready is seen high
  //------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    xfer(1'b1, a, wd, d, e);
  endtask

  // Code in the low half, parameter and channel flags above it
  task automatic cmd(input logic [15:0] code, input logic [1:0] fl, input logic [1:0] ch,
                     input logic [31:0] p);
    wr(OFS_CMD, {12'h000, ch, fl, code});
    wr(OFS_PARAM, p);
    wr(OFS_GO, 32'h1);
  endtask
endmodule // dcp_host_model

//--- sim/drive_command_parser_tb.sv
// Self-checking testbench of the drive command parser
module drive_command_parser_tb
  import dcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, buf_hold, ana_valid, nv_save;
  logic [7:0] paddr, control_mode_select;
  logic [31:0] pwdata, prdata, move_length;
  logic signed [15:0] ana_sample;
  logic [1:0] ana_chan;
  logic signed [16:0] analog_cmd;
  logic [15:0] ramp_up_rate, lfsr_q;
  int miscompares, checks_done, nv_pulses;

  dcp_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .buf_hold(buf_hold), .ana_sample(ana_sample), .ana_valid(ana_valid),
    .ana_chan(ana_chan), .analog_cmd(analog_cmd), .ramp_up_rate(ramp_up_rate),
    .move_length(move_length), .control_mode_select(control_mode_select), .nv_save(nv_save));

  dcp_host_model host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) if (nv_save === 1'b1) nv_pulses++;

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  // Thousandths of rps/s to 0.167 steps, rounded to nearest
  function automatic logic [31:0] ramp_steps(input logic [31:0] p);
    return (p + 32'd83) / 32'd167;
  endfunction

  function automatic logic signed [16:0] ana_next(input logic hyst, input logic signed [16:0] d,
                                                  input int db, input logic signed [16:0] prev);
    if (hyst) return ((d - prev > db) || (prev - d > db)) ? d : prev;
    return (d > db || -d > db) ? d : 17'sd0;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    host_u.xfer(1'b0, a, 32'h0, d, e);
    chk(d, exp);
  endtask

  // Busy and pending must both clear; polling is bounded by the watchdog
  task automatic wait_idle();
    logic [31:0] d;
    logic e;
    repeat (2) @(posedge clk);
    do host_u.xfer(1'b0, OFS_STAT, 32'h0, d, e); while (d[3:2] !== 2'b00);
  endtask

  task automatic run(input logic [15:0] c, input logic [1:0] fl, input logic [1:0] ch,
                     input logic [31:0] p);
    host_u.cmd(c, fl, ch, p);
    wait_idle();
  endtask

  task automatic err_chk(input logic exp);
    logic [31:0] d;
    logic e;
    host_u.xfer(1'b0, OFS_STAT, 32'h0, d, e);
    chk({31'h0, d[1]}, {31'h0, exp});
    host_u.wr(OFS_STAT, 32'h2);
  endtask

  task automatic finish_test();
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    logic [31:0] p, st, d;
    logic e;
    logic [7:0] db[3];
    logic signed [16:0] dv, exp_a;
    lfsr_q = 16'd19459;
    rst_n = 1'b0;
    ce = 1'b1;
    buf_hold = 1'b0;
    ana_sample = 16'sd0;
    ana_valid = 1'b0;
    ana_chan = 2'h0;
    nv_pulses = 0;
    exp_a = 17'sd0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFS_STAT, 32'h0);
    rdc(OFS_NV, 32'h0);
    host_u.xfer(1'b0, 8'h24, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    // Ramp rate: both range ends and random values
    for (int i = 0; i < 5; i++) begin
      p = (i == 0) ? RAMP_MIN : (i == 1) ? RAMP_MAX : 32'd167 + {rnd(), rnd()} % 32'd5461000;
      st = ramp_steps(p);
      run(CODE_RAMP_UP_RATE, 2'b01, 2'h0, p);
      chk({16'h0, ramp_up_rate}, st);
      run(CODE_RAMP_UP_RATE, 2'b00, 2'h0, 32'h0);
      rdc(OFS_RCODE, {16'h0, CODE_RAMP_UP_RATE});
      rdc(OFS_RVAL, st * 32'd167);
      run(CODE_REGISTER_QUERY, 2'b01, 2'h0, DREG_RAMP);
      rdc(OFS_RVAL, st);
      rdc(OFS_RCODE, {16'h0, CODE_REGISTER_QUERY});
    end
    rdc(OFS_NV, 32'h0);
    for (int k = 0; k < 2; k++) begin
      run(CODE_RAMP_UP_RATE, 2'b01, 2'h0, k ? 32'd5461168 : 32'd166);
      err_chk(1'b1);
      chk({16'h0, ramp_up_rate}, st);
    end
    // Move length: sign kept, illegal magnitude refused
    run(CODE_MOVE_LENGTH, 2'b01, 2'h0, 32'hffff_fffb);
    err_chk(1'b0);
    run(CODE_MOVE_LENGTH, 2'b01, 2'h0, MOVE_ILLEGAL);
    err_chk(1'b1);
    chk(move_length, 32'hffff_fffb);
    // Held buffered command must not delay an immediate query
    buf_hold <= 1'b1;
    host_u.cmd(CODE_MOVE_LENGTH, 2'b01, 2'h0, 32'h7fff_ffff);
    rdc(OFS_STAT, 32'h4);
    host_u.cmd(CODE_REGISTER_QUERY, 2'b01, 2'h0, DREG_MOVE);
    repeat (3) @(posedge clk);
    rdc(OFS_RVAL, 32'hffff_fffb);
    buf_hold <= 1'b0;
    wait_idle();
    chk(move_length, 32'h7fff_ffff);
    // Deadband per channel, then analog path in both modes
    host_u.wr(OFS_ZERO, 32'h10);
    for (int c = 0; c < 3; c++) begin
      db[c] = (c == 0) ? 8'hff : 8'(rnd());
      run(CODE_DEADBAND, 2'b11, 2'(c + 1), {24'h0, db[c]});
      run(CODE_DEADBAND, 2'b10, 2'(c + 1), 32'h0);
      rdc(OFS_RVAL, {24'h0, db[c]});
    end
    run(CODE_DEADBAND, 2'b11, 2'h0, 32'h5);
    err_chk(1'b1);
    run(CODE_DEADBAND, 2'b11, 2'h1, 32'h100);
    err_chk(1'b1);
    for (int m = 0; m < 2; m++) begin
      run(CODE_CONTROL_MODE_SELECT, 2'b01, 2'h0, m ? 32'h16 : 32'h0);
      chk({24'h0, control_mode_select}, m ? 32'h16 : 32'h0);
      ana_chan <= m ? 2'h2 : 2'h0;
      for (int i = 0; i < 40; i++) begin
        @(posedge clk);
        ana_sample <= $signed(16'(rnd() % 16'd1201)) - 16'sd600;
        ana_valid <= 1'b1;
        @(posedge clk);
        ana_valid <= 1'b0;
        dv = 17'(ana_sample) - 17'sd16;
        exp_a = ana_next(m[0], dv, int'(db[m ? 2 : 0]), exp_a);
        @(posedge clk);
        chk(32'(analog_cmd), 32'(exp_a));
      end
      rdc(OFS_ANA, 32'(exp_a));
      run(CODE_REGISTER_QUERY, 2'b01, 2'h0, DREG_ANA);
      rdc(OFS_RVAL, {15'h0, exp_a});
    end
    // Save pushes working settings to the persistent copy once
    rdc(OFS_NV, 32'h0);
    run(CODE_STORE_SETTINGS, 2'b00, 2'h0, 32'h0);
    chk(32'(nv_pulses), 32'h1);
    rdc(OFS_NV, {8'h16, 8'h00, st[15:0]});
    finish_test();
  end
endmodule // drive_command_parser_tb
